// ---- design/jfp_params.svh ----
// constants for the flash programming scan path
`ifndef JFP_PARAMS_SVH
`define JFP_PARAMS_SVH
`define JFP_IR_W 4
`define JFP_CMD_W 15
`define JFP_BYTE_W 8
`define JFP_EN_W 16
`define JFP_OP_ENABLE 4'h4
`define JFP_OP_COMMANDS 4'h5
`define JFP_OP_PAGELOAD 4'h6
`define JFP_OP_PAGEREAD 4'h7
`define JFP_OP_BYPASS 4'hf
`define JFP_UNLOCK_SIG 16'ha370
`define JFP_LOAD_WINDOW_TCK 11
`define JFP_TCK_NS 64
`define JFP_CLK_NS 5
`define JFP_TCK_MIN_CYC 8
`define JFP_FIFO_DEPTH 8
`endif

// ---- design/jfp_pkg.sv ----
// types for the flash programming scan path
package jfp_pkg;
  typedef enum logic [3:0] {
    JFP_RESET = 4'b0000,
    JFP_IDLE = 4'b0001,
    JFP_SEL_DR = 4'b0010,
    JFP_CAP_DR = 4'b0011,
    JFP_SHIFT_DR = 4'b0100,
    JFP_EXIT1_DR = 4'b0101,
    JFP_PAUSE_DR = 4'b0110,
    JFP_EXIT2_DR = 4'b0111,
    JFP_UPD_DR = 4'b1000,
    JFP_SEL_IR = 4'b1001,
    JFP_CAP_IR = 4'b1010,
    JFP_SHIFT_IR = 4'b1011,
    JFP_EXIT1_IR = 4'b1100,
    JFP_PAUSE_IR = 4'b1101,
    JFP_EXIT2_IR = 4'b1110,
    JFP_UPD_IR = 4'b1111
  } jfp_tap_t;
endpackage

// ---- design/jfp_fifo.sv ----
// small valid/ready fifo for the page-load byte stream
`timescale 1ns/100ps
module jfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("jfp_fifo: depth must be a power of two >= 2");
    end
  end
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } jfp_fifo_st_t;
  logic [WIDTH-1:0] mem [DEPTH];
  jfp_fifo_st_t st_reg;
  jfp_fifo_st_t st_next;
  logic push;
  logic pop;
  logic full;
  logic empty;
  assign full = (st_reg.wr[AW] != st_reg.rd[AW]) && (st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]);
  assign empty = st_reg.wr == st_reg.rd;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[st_reg.rd[AW-1:0]];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[st_reg.wr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ---- design/jfp_scan_path.sv ----
// test-access-port data path for flash command entry, page load and page read
//
// Function
// RULE1 - command-entry opcode puts the 15-bit command register between tdi and tdo
// RULE2 - capture-dr under command entry loads the previous command result
// RULE3 - shift-dr under command entry moves the command register once per tck
// RULE4 - update-dr under command entry applies the command word to flash inputs
// RULE5 - each run-test/idle pass under command entry gives one execute pulse
// RULE6 - page-load opcode selects the 8-bit byte register, low bits of command
// RULE7 - page-load update copies byte to holding register, writes buffer within 11 tck
// RULE8 - page-load updates alternate low then high byte, first one low
// RULE9 - page load increments counter before each low write except the first
// RULE10 - page-read opcode selects the 8-bit byte register
// RULE11 - page-read capture takes addressed flash byte, alternating, low first
// RULE12 - page read increments counter after every high-byte capture
// RULE13 - shift-dr under load or read shifts the byte register once per tck
// RULE14 - all shift registers move least significant bit first
// RULE15 - instruction register is four bits wide
// RULE16 - programming paths work only after the unlock signature matched
// RULE17 - programmer sets the start address via command entry first; the counter here is never loaded from a command word
`timescale 1ns/100ps
`include "jfp_params.svh"
module jfp_scan_path #(
  parameter int CMD_W = `JFP_CMD_W,
  parameter int BYTE_W = `JFP_BYTE_W,
  parameter int PC_W = 13,
  parameter int FIFO_DEPTH = `JFP_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  output logic [CMD_W-1:0] flash_cmd,
  output logic flash_cmd_valid,
  output logic flash_exec,
  input wire logic [CMD_W-1:0] flash_result,
  output logic [PC_W-1:0] flash_pc,
  input wire logic [2*BYTE_W-1:0] flash_rdata,
  output logic [BYTE_W-1:0] pbuf_data,
  output logic pbuf_high,
  output logic [PC_W-1:0] pbuf_addr,
  output logic pbuf_we,
  output logic prog_enabled
);
  import jfp_pkg::*;
  localparam int ETCK = `JFP_TCK_NS / `JFP_CLK_NS;
  // a byte reaches the buffer two system clocks after update-dr loads the holding register
  localparam int LOAD_CYC = (`JFP_LOAD_WINDOW_TCK * `JFP_TCK_NS) / `JFP_CLK_NS;
  initial begin
    if (CMD_W != `JFP_CMD_W || BYTE_W != `JFP_BYTE_W || PC_W < 1 || PC_W > 24) begin
      $error("jfp_scan_path: unsupported widths");
    end
    if (FIFO_DEPTH * 4 > LOAD_CYC) begin
      $error("jfp_scan_path: fifo too deep for the load window");
    end
    // each tck level must outlast the three-stage edge detector
    if (ETCK < `JFP_TCK_MIN_CYC) begin
      $error("jfp_scan_path: tck too fast for the edge detector");
    end
  end
  //////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    jfp_tap_t tap;
    logic [`JFP_IR_W-1:0] ir_sh;
    logic [`JFP_IR_W-1:0] ir;
    logic [CMD_W-1:0] cmd_sh;
    logic [`JFP_EN_W-1:0] en_sh;
    logic bypass;
    logic unlocked;
    logic load_high;
    logic load_first;
    logic read_high;
    logic [BYTE_W-1:0] hold;
    logic hold_high;
    logic hold_valid;
    logic [PC_W-1:0] pc;
    logic [CMD_W-1:0] cmd_out;
    logic cmd_valid;
    logic exec;
    logic tdo;
    logic tdo_oe_n;
    logic [BYTE_W-1:0] wr_data;
    logic wr_high;
    logic [PC_W-1:0] wr_addr;
    logic wr_en;
  } jfp_st_t;
  jfp_st_t st_reg;
  jfp_st_t st_next;
  logic tck_rise;
  logic tck_fall;
  logic f_in_ready;
  logic f_out_valid;
  logic [BYTE_W+PC_W:0] f_in_data;
  logic [BYTE_W+PC_W:0] f_out_data;
  logic f_push;

  // next controller state for the tms value seen at a tck rise
  function automatic jfp_tap_t tap_step(input jfp_tap_t s, input logic m);
    case (s)
      JFP_RESET: tap_step = m ? JFP_RESET : JFP_IDLE;
      JFP_IDLE: tap_step = m ? JFP_SEL_DR : JFP_IDLE;
      JFP_SEL_DR: tap_step = m ? JFP_SEL_IR : JFP_CAP_DR;
      JFP_CAP_DR: tap_step = m ? JFP_EXIT1_DR : JFP_SHIFT_DR;
      JFP_SHIFT_DR: tap_step = m ? JFP_EXIT1_DR : JFP_SHIFT_DR;
      JFP_EXIT1_DR: tap_step = m ? JFP_UPD_DR : JFP_PAUSE_DR;
      JFP_PAUSE_DR: tap_step = m ? JFP_EXIT2_DR : JFP_PAUSE_DR;
      JFP_EXIT2_DR: tap_step = m ? JFP_UPD_DR : JFP_SHIFT_DR;
      JFP_UPD_DR: tap_step = m ? JFP_SEL_DR : JFP_IDLE;
      JFP_SEL_IR: tap_step = m ? JFP_RESET : JFP_CAP_IR;
      JFP_CAP_IR: tap_step = m ? JFP_EXIT1_IR : JFP_SHIFT_IR;
      JFP_SHIFT_IR: tap_step = m ? JFP_EXIT1_IR : JFP_SHIFT_IR;
      JFP_EXIT1_IR: tap_step = m ? JFP_UPD_IR : JFP_PAUSE_IR;
      JFP_PAUSE_IR: tap_step = m ? JFP_EXIT2_IR : JFP_PAUSE_IR;
      JFP_EXIT2_IR: tap_step = m ? JFP_UPD_IR : JFP_SHIFT_IR;
      JFP_UPD_IR: tap_step = m ? JFP_SEL_DR : JFP_IDLE;
      default: tap_step = JFP_RESET;
    endcase
  endfunction

  // an opcode only acts on flash once the unlock signature has matched
  function automatic logic op_open(input logic [`JFP_IR_W-1:0] code, input logic en,
                                   input logic [`JFP_IR_W-1:0] op);
    op_open = en && (code == op);
  endfunction

  // the command register, or its low byte, is the path between tdi and tdo
  function automatic logic uses_cmd_reg(input logic [`JFP_IR_W-1:0] code);
    case (code)
      `JFP_OP_COMMANDS, `JFP_OP_PAGELOAD, `JFP_OP_PAGEREAD: uses_cmd_reg = 1'b1;
      default: uses_cmd_reg = 1'b0;
    endcase
  endfunction

  // shift right: bit 0 leaves first, tdi enters at the top
  function automatic logic [CMD_W-1:0] shr(input logic [CMD_W-1:0] v, input int w,
                                           input logic d);
    logic [CMD_W-1:0] r;
    r = v >> 1;
    r[w-1] = d;
    return r;
  endfunction

  // second and third stages only; stage 0 feeds stage 1 alone
  assign tck_rise = st_reg.tck_s[1] && !st_reg.tck_s[2];
  assign tck_fall = !st_reg.tck_s[1] && st_reg.tck_s[2];
  //////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.tck_s = {st_reg.tck_s[1:0], tck};
    st_next.tms_s = {st_reg.tms_s[0], tms};
    st_next.tdi_s = {st_reg.tdi_s[0], tdi};
    st_next.exec = 1'b0;
    st_next.wr_en = 1'b0;
    f_push = 1'b0;
    f_in_data = {st_reg.hold_high, st_reg.pc, st_reg.hold};
    if (tck_rise) begin
      st_next.tap = tap_step(st_reg.tap, st_reg.tms_s[1]);
      case (st_reg.tap)
        JFP_RESET: begin
          st_next.ir = `JFP_OP_BYPASS;
        end
        JFP_CAP_IR: begin
          st_next.ir_sh = `JFP_IR_W'(1);
        end
        JFP_SHIFT_IR: begin
          st_next.ir_sh = {st_reg.tdi_s[1], st_reg.ir_sh[`JFP_IR_W-1:1]}; // RULE14 RULE15
        end
        JFP_UPD_IR: begin
          st_next.ir = st_reg.ir_sh; // RULE15
          st_next.load_high = 1'b0; // RULE8
          st_next.load_first = 1'b1; // RULE9
          st_next.read_high = 1'b0; // RULE11
        end
        JFP_CAP_DR: begin
          st_next.bypass = 1'b0;
          if (op_open(st_reg.ir, st_reg.unlocked, `JFP_OP_COMMANDS)) begin
            st_next.cmd_sh = flash_result; // RULE2
          end else if (op_open(st_reg.ir, st_reg.unlocked, `JFP_OP_PAGEREAD)) begin
            st_next.cmd_sh[BYTE_W-1:0] = st_reg.read_high ? flash_rdata[2*BYTE_W-1:BYTE_W] :
                                         flash_rdata[BYTE_W-1:0]; // RULE11
            st_next.read_high = !st_reg.read_high; // RULE11
            // post-increment after the high byte, even past the page end
            if (st_reg.read_high) begin
              st_next.pc = st_reg.pc + 1'b1; // RULE12
            end
          end
        end
        JFP_SHIFT_DR: begin
          case (st_reg.ir)
            `JFP_OP_ENABLE: st_next.en_sh = {st_reg.tdi_s[1], st_reg.en_sh[`JFP_EN_W-1:1]};
            `JFP_OP_COMMANDS: st_next.cmd_sh = shr(st_reg.cmd_sh, CMD_W,
                                                   st_reg.tdi_s[1]); // RULE1 RULE3 RULE14
            `JFP_OP_PAGELOAD, `JFP_OP_PAGEREAD: st_next.cmd_sh = shr(st_reg.cmd_sh, BYTE_W,
                                                   st_reg.tdi_s[1]); // RULE6 RULE10 RULE13
            default: st_next.bypass = st_reg.tdi_s[1];
          endcase
        end
        JFP_UPD_DR: begin
          if (st_reg.ir == `JFP_OP_ENABLE) begin
            st_next.unlocked = st_reg.en_sh == `JFP_UNLOCK_SIG; // RULE16
          end else if (op_open(st_reg.ir, st_reg.unlocked, `JFP_OP_COMMANDS)) begin
            st_next.cmd_out = st_reg.cmd_sh; // RULE4
            st_next.cmd_valid = 1'b1;
          end else if (op_open(st_reg.ir, st_reg.unlocked, `JFP_OP_PAGELOAD)) begin
            st_next.hold = st_reg.cmd_sh[BYTE_W-1:0]; // RULE7
            st_next.hold_high = st_reg.load_high; // RULE8
            st_next.load_high = !st_reg.load_high; // RULE8
            st_next.load_first = 1'b0;
            // pre-increment keeps the last page word from stepping out of the page
            if (!st_reg.load_high && !st_reg.load_first) begin
              st_next.pc = st_reg.pc + 1'b1; // RULE9
            end
            st_next.hold_valid = 1'b1;
          end
        end
        JFP_IDLE: begin
          if (op_open(st_reg.ir, st_reg.unlocked, `JFP_OP_COMMANDS)) begin
            st_next.exec = 1'b1; // RULE5
          end
        end
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      // tdo changes on the falling test clock edge
      st_next.tdo_oe_n = !(st_reg.tap == JFP_SHIFT_DR || st_reg.tap == JFP_SHIFT_IR);
      if (st_reg.tap == JFP_SHIFT_IR) begin
        st_next.tdo = st_reg.ir_sh[0]; // RULE14
      end else if (st_reg.ir == `JFP_OP_ENABLE) begin
        st_next.tdo = st_reg.en_sh[0];
      end else if (uses_cmd_reg(st_reg.ir)) begin
        st_next.tdo = st_reg.cmd_sh[0]; // RULE1 RULE6 RULE10
      end else begin
        st_next.tdo = st_reg.bypass;
      end
    end
    // holding register drains into the fifo, then to the page buffer
    if (st_reg.hold_valid && f_in_ready && !(tck_rise && st_reg.tap == JFP_UPD_DR)) begin
      f_push = 1'b1; // RULE7
      st_next.hold_valid = 1'b0;
    end
    if (f_out_valid) begin
      st_next.wr_en = 1'b1; // RULE7
      st_next.wr_data = f_out_data[BYTE_W-1:0];
      st_next.wr_addr = f_out_data[BYTE_W+PC_W-1:BYTE_W];
      st_next.wr_high = f_out_data[BYTE_W+PC_W];
    end
    if (st_reg.cmd_valid && st_reg.ir != `JFP_OP_COMMANDS) begin
      st_next.cmd_valid = 1'b0;
    end
    if (!st_reg.unlocked) begin
      st_next.cmd_valid = 1'b0; // RULE16
    end
  end
  //////////////////////////////////////////////////////////////////////
  // the controller wakes in test-logic-reset with the bypass opcode loaded
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.tap <= JFP_RESET;
      st_reg.ir <= `JFP_OP_BYPASS;
      st_reg.tdo_oe_n <= 1'b1;
      st_reg.load_first <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // the page buffer takes a byte every cycle, so the fifo drains at once
  jfp_fifo #(
    .WIDTH(BYTE_W + PC_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_jfp_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(f_push),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(1'b1),
    .out_data(f_out_data)
  );

  assign tdo = st_reg.tdo;
  assign tdo_oe_n = st_reg.tdo_oe_n;
  assign flash_cmd = st_reg.cmd_out;
  assign flash_cmd_valid = st_reg.cmd_valid;
  assign flash_exec = st_reg.exec;
  assign flash_pc = st_reg.pc;
  assign pbuf_data = st_reg.wr_data;
  assign pbuf_high = st_reg.wr_high;
  assign pbuf_addr = st_reg.wr_addr;
  assign pbuf_we = st_reg.wr_en;
  assign prog_enabled = st_reg.unlocked;
endmodule

// ---- testbench/jfp_prog_model.sv ----
// programmer model driving the test access port
`timescale 1ns/100ps
module jfp_prog_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one tck period; tdo read before the rise, pulled up when released
  task automatic pulse(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #32 o = tdo_oe_n ? 1'b1 : tdo;
    tck = 1'b1;
    #32 tck = 1'b0;
  endtask
  task automatic idle(input int k);
    logic o;
    repeat (k) pulse(1'b0, 1'b0, o);
  endtask
  // walk from idle to shift, shift n bits, end back in idle
  task automatic scan(input logic ir, input logic [15:0] d, input int n,
                      output logic [15:0] q);
    logic o;
    q = '0;
    pulse(1'b1, 1'b0, o);
    if (ir) pulse(1'b1, 1'b0, o);
    pulse(1'b0, 1'b0, o);
    pulse(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, d[i], o);
      q[i] = o;
    end
    pulse(1'b1, 1'b0, o);
    pulse(1'b0, 1'b0, o);
  endtask
endmodule

// ---- testbench/jfp_scan_checker.sv ----
// port-level assertions for the flash programming scan path
`timescale 1ns/100ps
module jfp_scan_checker #(
  parameter int PC_W = 13,
  parameter int CMD_W = 15
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tdo,
  input wire logic [CMD_W-1:0] flash_cmd,
  input wire logic flash_cmd_valid,
  input wire logic flash_exec,
  input wire logic [PC_W-1:0] flash_pc,
  input wire logic pbuf_high,
  input wire logic [PC_W-1:0] pbuf_addr,
  input wire logic pbuf_we,
  input wire logic prog_enabled
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [PC_W-1:0] low_addr_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_addr_reg <= '0;
    end else if (pbuf_we && !pbuf_high) begin
      low_addr_reg <= pbuf_addr;
    end
  end
  sequence s_exec_pulse;
    flash_exec ##1 !flash_exec;
  endsequence
  sequence s_we_pulse;
    pbuf_we ##1 !pbuf_we;
  endsequence
  a_exec_one_cycle: assert property ($rose(flash_exec) |-> s_exec_pulse)
    else $error("exec pulse too long");
  a_exec_when_open: assert property (flash_exec |-> prog_enabled)
    else $error("exec while locked");
  a_we_one_cycle: assert property ($rose(pbuf_we) |-> s_we_pulse)
    else $error("write strobe too long");
  a_we_when_open: assert property (pbuf_we |-> prog_enabled)
    else $error("write while locked");
  a_valid_when_open: assert property (flash_cmd_valid |-> prog_enabled)
    else $error("command valid while locked");
  a_cmd_on_update: assert property ($changed(flash_cmd) |-> flash_cmd_valid)
    else $error("command word moved without update");
  a_high_same_word: assert property (pbuf_we && pbuf_high |->
    pbuf_addr == low_addr_reg)
    else $error("high byte to other word");
  a_pc_single_step: assert property ($changed(flash_pc) |->
    flash_pc == PC_W'($past(flash_pc) + 1'b1))
    else $error("counter jumped");
  a_tdo_after_fall: assert property ($changed(tdo) |-> !tck && !$past(tck, 3))
    else $error("tdo moved outside low tck");
endmodule
bind jfp_scan_path jfp_scan_checker #(.PC_W(PC_W), .CMD_W(CMD_W)) u_jfp_scan_checker (
  .sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tdo(tdo), .flash_cmd(flash_cmd),
  .flash_cmd_valid(flash_cmd_valid), .flash_exec(flash_exec), .flash_pc(flash_pc),
  .pbuf_high(pbuf_high), .pbuf_addr(pbuf_addr), .pbuf_we(pbuf_we),
  .prog_enabled(prog_enabled));

// ---- testbench/tb_top.sv ----
// self-checking bench for the flash programming scan path
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic sys_clk, reset_n, tck, tms, tdi, tdo, tdo_oe_n;
  logic flash_cmd_valid, flash_exec, pbuf_high, pbuf_we, prog_enabled;
  logic [14:0] flash_cmd, flash_result;
  logic [12:0] flash_pc, pbuf_addr;
  logic [15:0] flash_rdata;
  logic [7:0] pbuf_data;
  int miscompares, cmp_count, exec_n;
  logic [21:0] wq[$];
  assign flash_rdata = {3'h5, flash_pc} ^ 16'h5a3c;
  jfp_scan_path u_jfp_scan_path (.sys_clk(sys_clk), .reset_n(reset_n), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .flash_cmd(flash_cmd),
    .flash_cmd_valid(flash_cmd_valid), .flash_exec(flash_exec),
    .flash_result(flash_result), .flash_pc(flash_pc), .flash_rdata(flash_rdata),
    .pbuf_data(pbuf_data), .pbuf_high(pbuf_high), .pbuf_addr(pbuf_addr),
    .pbuf_we(pbuf_we), .prog_enabled(prog_enabled));
  jfp_prog_model u_jfp_prog_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (flash_exec) exec_n++;
    if (pbuf_we) wq.push_back({pbuf_data, pbuf_high, pbuf_addr});
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_locked;
    logic [15:0] q;
    u_jfp_prog_model.scan(1'b1, 16'h0005, 4, q);
    u_jfp_prog_model.scan(1'b0, 16'h1234, 15, q);
    u_jfp_prog_model.idle(1);
    u_jfp_prog_model.scan(1'b1, 16'h0004, 4, q);
    u_jfp_prog_model.scan(1'b0, 16'ha371, 16, q);
    `CHK("valid", 1'b0, flash_cmd_valid)
    `CHK("exec", 0, exec_n)
    `CHK("enabled", 1'b0, prog_enabled)
    u_jfp_prog_model.scan(1'b0, 16'ha370, 16, q);
    `CHK("enabled", 1'b1, prog_enabled)
    $display("test locked done");
  endtask
  task automatic t_command;
    logic [15:0] q;
    u_jfp_prog_model.scan(1'b1, 16'h0005, 4, q);
    u_jfp_prog_model.scan(1'b0, 16'h1234, 15, q);
    `CHK("result", 15'h2b5d, q[14:0])
    `CHK("cmd", 15'h1234, flash_cmd)
    `CHK("valid", 1'b1, flash_cmd_valid)
    `CHK("oe", 1'b1, tdo_oe_n)
    exec_n = 0;
    u_jfp_prog_model.idle(2);
    `CHK("exec", 2, exec_n)
    $display("test command done");
  endtask
  task automatic t_load;
    logic [15:0] q;
    logic [12:0] p0;
    logic [21:0] ex;
    int k;
    // the start address left by the command path is whatever the counter holds
    p0 = flash_pc;
    u_jfp_prog_model.scan(1'b1, 16'h0006, 4, q);
    wq.delete();
    for (int i = 0; i < 4; i++) u_jfp_prog_model.scan(1'b0, 16'(8'h96 ^ 8'(i * 17)), 8, q);
    k = 0;
    while (wq.size() < 4 && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 100) begin
      miscompares++;
      end_of_test();
    end
    for (int i = 0; i < 4; i++) begin
      ex = {8'(8'h96 ^ 8'(i * 17)), 1'(i), 13'(p0 + i / 2)};
      `CHK("write", ex, wq[i])
    end
    `CHK("pc", 13'(p0 + 1), flash_pc)
    $display("test load done");
  endtask
  task automatic t_read;
    logic [15:0] q, w;
    logic [12:0] p0;
    p0 = flash_pc;
    for (int i = 0; i < 5; i++) begin
      if (i == 0 || i == 4) u_jfp_prog_model.scan(1'b1, 16'h0007, 4, q);
      u_jfp_prog_model.scan(1'b0, 16'h0000, 8, q);
      w = {3'h5, 13'(p0 + i / 2)} ^ 16'h5a3c;
      `CHK("read", (i % 2) ? w[15:8] : w[7:0], q[7:0])
    end
    `CHK("pc", 13'(p0 + 2), flash_pc)
    $display("test read done");
  endtask
  initial begin
    reset_n = 1'b0;
    flash_result = 15'h2b5d;
    miscompares = 0;
    cmp_count = 0;
    exec_n = 0;
    repeat (10) @(posedge sys_clk);
    #1.2 reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1.2 u_jfp_prog_model.idle(1);
    t_locked();
    t_command();
    t_load();
    t_read();
    end_of_test();
  end
endmodule
